//--- watchdog_with_soft_reset.sv
// The Avalon-MM register port is this design's own decision.
`include "wdog_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module watchdog_with_soft_reset (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire wdog_pkg::avmm_req_type bus_req_i,
   output var wdog_pkg::avmm_rsp_type bus_rsp_o,
   input wire logic power_down_i,
   input wire logic idle_i,
   input wire logic double_speed_mode_i,
   input wire logic [6:0] timer_prescale_value_i,
   output logic cpu_reset_o,
   output logic reset_pin_o,
   output logic reset_pin_oe_o,
   output logic irq_o
);
   import wdog_pkg::*;

   logic [7:0] cfg_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   key_state_type key_reg;
   logic [6:0] presc_reg;
   logic [20:0] cnt_reg;
   logic [6:0] pulse_reg;
   logic pulse_pin_reg;
   logic [31:0] rdata_reg;
   logic ack_reg;
   logic pd_meta_reg;
   logic pd_reg;
   logic idle_meta_reg;
   logic idle_sync_reg;

   logic wr;
   logic rd;
   logic key_wr;
   logic feed;
   logic sw_good;
   logic sw_bad;
   logic timeout;
   logic tick;
   logic running;
   logic halted;
   logic [20:0] limit;
   logic [1:0] irq_clear;
   logic [1:0] irq_set;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // last count value before the timeout, one entry per period select
   function automatic logic [20:0] period_limit(input logic [2:0] sel);
      case (sel)
         3'h0: period_limit = 21'h003FFF;
         3'h1: period_limit = 21'h007FFF;
         3'h2: period_limit = 21'h00FFFF;
         3'h3: period_limit = 21'h01FFFF;
         3'h4: period_limit = 21'h03FFFF;
         3'h5: period_limit = 21'h07FFFF;
         3'h6: period_limit = 21'h0FFFFF;
         default: period_limit = 21'h1FFFFF;
      endcase
   endfunction

   // one wait state per access so the read mux is registered
   // writes land on the edge that ends the wait, as the master sees it
   assign wr = bus_req_i.write && ack_reg;
   assign rd = bus_req_i.read && !ack_reg;
   assign bus_rsp_o.waitrequest = (bus_req_i.read || bus_req_i.write) && !ack_reg;
   assign bus_rsp_o.readdata = rdata_reg;
   assign key_wr = wr && hit(bus_req_i.address, `KEY_OFFSET);
   assign running = cfg_reg[`BIT_RUN];

   // power-down and idle come from outside this clock domain
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pd_meta_reg <= 1'b0;
         pd_reg <= 1'b0;
         idle_meta_reg <= 1'b0;
         idle_sync_reg <= 1'b0;
      end else begin
         pd_meta_reg <= power_down_i;
         pd_reg <= pd_meta_reg;
         idle_meta_reg <= idle_i;
         idle_sync_reg <= idle_meta_reg;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (bus_req_i.read || bus_req_i.write) && !ack_reg;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         key_reg <= KEY_IDLE;
      end else if (key_wr) begin
         case (key_reg)
            KEY_IDLE: begin
               if (bus_req_i.writedata[7:0] == `KEY_EN1) begin
                  key_reg <= KEY_EN_WAIT;
               end else if (bus_req_i.writedata[7:0] == `KEY_SW1) begin
                  key_reg <= KEY_SW_WAIT;
               end else begin
                  key_reg <= KEY_IDLE;
               end
            end
            default: begin
               key_reg <= KEY_IDLE;
            end
         endcase
      end
   end

   // a write to another register between the keys also raises sw_bad, but key_reg stays in its wait state
   always_comb begin
      feed = key_wr && key_reg == KEY_EN_WAIT && bus_req_i.writedata[7:0] == `KEY_EN2;
      sw_good = key_wr && key_reg == KEY_SW_WAIT && bus_req_i.writedata[7:0] == `KEY_SW2;
      sw_bad = 1'b0;
      if (key_wr && !feed && !sw_good) begin
         sw_bad = key_reg != KEY_IDLE ||
            (bus_req_i.writedata[7:0] != `KEY_EN1 && bus_req_i.writedata[7:0] != `KEY_SW1);
      end
      if (wr && !key_wr && key_reg != KEY_IDLE) begin
         sw_bad = 1'b1;
      end
   end

   assign halted = pd_reg || (idle_sync_reg && cfg_reg[`BIT_IDLE]) || !running;
   assign tick = !halted && presc_reg == timer_prescale_value_i;
   assign limit = period_limit(cfg_reg[2:0]);
   assign timeout = tick && cnt_reg == limit;

   // 14-bit counter extended by the period select bits
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || feed || pulse_reg != 7'h00) begin
         presc_reg <= 7'h00;
         cnt_reg <= 21'h000000;
      end else if (!halted) begin
         presc_reg <= tick ? 7'h00 : presc_reg + 7'h01;
         if (tick) begin
            cnt_reg <= cnt_reg + 21'h000001;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pulse_reg <= 7'h00;
         pulse_pin_reg <= 1'b0;
      end else if (pulse_reg == 7'h00 && (timeout || sw_good || sw_bad)) begin
         pulse_reg <= double_speed_mode_i ? `RST_PULSE_CYCLES_X2 : `RST_PULSE_CYCLES;
         pulse_pin_reg <= !cfg_reg[`BIT_DISRO];
      end else if (pulse_reg != 7'h00) begin
         pulse_reg <= pulse_reg - 7'h01;
         pulse_pin_reg <= pulse_reg != 7'h01 && pulse_pin_reg;
      end
   end

   assign cpu_reset_o = pulse_reg != 7'h00;
   assign reset_pin_o = 1'b0;
   assign reset_pin_oe_o = pulse_pin_reg;

   // hardware set wins over the software clear; running drops as the reset pulse ends
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cfg_reg <= `CFG_RESET;
      end else begin
         if (wr && hit(bus_req_i.address, `CFG_OFFSET)) begin
            cfg_reg[4:0] <= bus_req_i.writedata[4:0];
            if (!bus_req_i.writedata[`BIT_OVF]) begin
               cfg_reg[`BIT_OVF] <= 1'b0;
            end
            if (!bus_req_i.writedata[`BIT_SWR]) begin
               cfg_reg[`BIT_SWR] <= 1'b0;
            end
         end
         if (feed) begin
            cfg_reg[`BIT_RUN] <= 1'b1;
         end else if (pulse_reg == 7'h01) begin
            cfg_reg[`BIT_RUN] <= 1'b0;
         end
         if (timeout || sw_bad) begin
            cfg_reg[`BIT_OVF] <= 1'b1;
         end
         if (sw_good || sw_bad) begin
            cfg_reg[`BIT_SWR] <= 1'b1;
         end
      end
   end

   // bit0 timeout reset, bit1 software reset
   always_comb begin
      irq_clear = 2'h0;
      if (wr && hit(bus_req_i.address, `IRQ_STAT_OFFSET)) begin
         irq_clear = bus_req_i.writedata[1:0];
      end
      irq_set = {sw_good || sw_bad, timeout};
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
      end else begin
         if (wr && hit(bus_req_i.address, `IRQ_MASK_OFFSET)) begin
            irq_mask_reg <= bus_req_i.writedata[1:0];
         end
         irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_set;
      end
   end

   assign irq_o = |(irq_stat_reg & irq_mask_reg);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h00000000;
      end else if (rd) begin
         case (bus_req_i.address)
            `CFG_OFFSET: rdata_reg <= {24'h000000, cfg_reg};
            `IRQ_STAT_OFFSET: rdata_reg <= {30'h00000000, irq_stat_reg};
            `IRQ_MASK_OFFSET: rdata_reg <= {30'h00000000, irq_mask_reg};
            default: rdata_reg <= 32'h00000000;
         endcase
      end
   end

   pulse_len_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(cpu_reset_o) && !double_speed_mode_i |-> cpu_reset_o [*8])
      else $error("reset pulse too short");
   feed_run_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      feed |=> running) else $error("feed did not set running");
   sw_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sw_good |=> cfg_reg[`BIT_SWR] && cpu_reset_o) else $error("software reset missed");
   bad_key_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sw_bad |=> cfg_reg[`BIT_OVF] && cfg_reg[`BIT_SWR]) else $error("bad key flags");
   timeout_ovf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      timeout |=> cfg_reg[`BIT_OVF] && cpu_reset_o) else $error("timeout not flagged");
   pin_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      reset_pin_oe_o |-> cpu_reset_o) else $error("pin driven outside pulse");
   feed_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      feed |=> cnt_reg == 21'h000000 && presc_reg == 7'h00) else $error("feed no clear");
   halt_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pd_reg && !feed && !cpu_reset_o |=> $stable(cnt_reg)) else $error("counted in power-down");
   tick_gap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      tick && timer_prescale_value_i == 7'h05 && $stable(timer_prescale_value_i) |=> !tick [*5])
      else $error("prescale spacing");

   wait_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(bus_req_i.read || bus_req_i.write) |-> bus_rsp_o.waitrequest)
      else $error("new request not held off");

   wait_drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      bus_rsp_o.waitrequest |=> !bus_rsp_o.waitrequest)
      else $error("wait longer than one cycle");

   count_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cpu_reset_o && $past(cpu_reset_o) |-> cnt_reg == 21'h000000 && presc_reg == 7'h00)
      else $error("counter ran during reset pulse");

   run_drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $fell(cpu_reset_o) && !$past(feed) |-> !running)
      else $error("still running after reset pulse");

   pin_disable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(cpu_reset_o) && $past(cfg_reg[`BIT_DISRO]) |-> !reset_pin_oe_o)
      else $error("pin driven while disabled");

   timeout_stat_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      timeout |=> irq_stat_reg[0])
      else $error("timeout status missed");

   swr_stat_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sw_good || sw_bad |=> irq_stat_reg[1])
      else $error("software reset status missed");

   pulse_end_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(cpu_reset_o) |-> ##[1:96] !cpu_reset_o)
      else $error("reset pulse too long");

   pulse_short_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(cpu_reset_o) && $past(double_speed_mode_i) |-> ##[1:48] !cpu_reset_o)
      else $error("double speed pulse too long");

   pulse_full_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(cpu_reset_o) && !$past(double_speed_mode_i) |-> ##95 cpu_reset_o)
      else $error("reset pulse ended early");

   key_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      feed |=> key_reg == KEY_IDLE)
      else $error("key sequence not restarted");

   bad_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sw_bad && !cpu_reset_o |=> cpu_reset_o)
      else $error("bad key gave no reset");

   idle_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      idle_sync_reg && cfg_reg[`BIT_IDLE] && !feed && !cpu_reset_o |=> $stable(cnt_reg))
      else $error("counted in idle halt");

   feed_c: cover property (@(posedge ref_clk_i) feed);
   pulse_c: cover property (@(posedge ref_clk_i) $fell(cpu_reset_o));
   sw_c: cover property (@(posedge ref_clk_i) sw_good);
   bad_c: cover property (@(posedge ref_clk_i) sw_bad);
   timeout_c: cover property (@(posedge ref_clk_i) timeout);
endmodule
`default_nettype wire

//--- watchdog_with_soft_reset_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "wdog_defs.svh"
module watchdog_with_soft_reset_test;
   import wdog_pkg::*;
   typedef struct {logic [7:0] a; logic rd; logic [7:0] d; logic [7:0] e;} row_type;
   logic ref_clk_i, rst_i, power_down_i, idle_i, double_speed_mode_i;
   logic [6:0] timer_prescale_value_i;
   avmm_req_type bus_req;
   avmm_rsp_type bus_rsp;
   logic cpu_reset, reset_pin, reset_pin_oe, irq, oe_seen;
   logic [31:0] q;
   int bad_count = 0, n_compared = 0, cyc = 0, plen = 0, last_len = 0, pulses = 0;
   int rise_cyc = 0, t0 = 0, wn = 0;
   row_type rows [9] = '{
      '{`CFG_OFFSET, 1'b0, 8'h1F, 8'h00}, '{`CFG_OFFSET, 1'b1, 8'h00, 8'h1F},
      '{`CFG_OFFSET, 1'b0, 8'hE0, 8'h00}, '{`CFG_OFFSET, 1'b1, 8'h00, 8'h00},
      '{`KEY_OFFSET, 1'b1, 8'h00, 8'h00}, '{`CTRL_OFFSET, 1'b0, 8'hFF, 8'h00},
      '{`CTRL_OFFSET, 1'b1, 8'h00, 8'h00}, '{`IRQ_MASK_OFFSET, 1'b0, 8'h03, 8'h00},
      '{`IRQ_MASK_OFFSET, 1'b1, 8'h00, 8'h03}};

   watchdog_with_soft_reset u_watchdog_with_soft_reset (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req), .bus_rsp_o(bus_rsp),
      .power_down_i(power_down_i), .idle_i(idle_i),
      .double_speed_mode_i(double_speed_mode_i),
      .timer_prescale_value_i(timer_prescale_value_i), .cpu_reset_o(cpu_reset),
      .reset_pin_o(reset_pin), .reset_pin_oe_o(reset_pin_oe), .irq_o(irq));

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task complete_run;
      if (bad_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // values read right at the edge are those the design sampled there
   task automatic acc(input logic [7:0] a, input logic r, input logic [7:0] d);
      int n;
      n = 0;
      bus_req.address <= a;
      bus_req.read <= r;
      bus_req.write <= !r;
      bus_req.writedata <= {24'h000000, d};
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0);
      q = bus_rsp.readdata;
      bus_req.read <= 1'b0;
      bus_req.write <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      acc(a, 1'b1, 8'h00);
      chk(q, {24'h000000, e});
   endtask

   task automatic key(input logic [7:0] d);
      acc(`KEY_OFFSET, 1'b0, d);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   always @(posedge ref_clk_i) cyc <= cyc + 1;

   // pulse length and pin drive, tracked apart from the bus traffic
   always @(negedge ref_clk_i) begin
      if (cpu_reset === 1'b1) begin
         if (plen == 0) begin
            rise_cyc = cyc;
            oe_seen = 1'b0;
         end
         plen++;
         if (reset_pin_oe === 1'b1) oe_seen = 1'b1;
         if (reset_pin_oe === 1'b1) chk(reset_pin, 32'h0);
      end else if (plen != 0) begin
         last_len = plen;
         pulses++;
         plen = 0;
      end
   end

   initial begin
      #400000;
      bad_count++;
      complete_run;
   end

   initial begin
      rst_i = 1'b1;
      power_down_i = 1'b0;
      idle_i = 1'b0;
      double_speed_mode_i = 1'b0;
      timer_prescale_value_i = 7'h05;
      bus_req = '0;
      idle(20);
      rst_i <= 1'b0;
      idle(1);
      chk({cpu_reset, reset_pin_oe, irq}, 32'h0);
      rdchk(`CFG_OFFSET, `CFG_RESET);
      foreach (rows[i]) begin
         acc(rows[i].a, rows[i].rd, rows[i].d);
         if (rows[i].rd) chk(q, {24'h000000, rows[i].e});
      end
      key(`KEY_EN1);
      rdchk(`CFG_OFFSET, 8'h00);
      key(`KEY_EN2);
      rdchk(`CFG_OFFSET, 8'h20);
      key(`KEY_SW1);
      key(`KEY_SW2);
      idle(150);
      chk(pulses, 32'h1);
      chk(last_len, `RST_PULSE_CYCLES);
      chk(oe_seen, 32'h1);
      rdchk(`CFG_OFFSET, 8'h40);
      rdchk(`IRQ_STAT_OFFSET, 8'h02);
      chk(irq, 32'h1);
      acc(`IRQ_MASK_OFFSET, 1'b0, 8'h00);
      chk(irq, 32'h0);
      acc(`IRQ_MASK_OFFSET, 1'b0, 8'h03);
      acc(`IRQ_STAT_OFFSET, 1'b0, 8'h02);
      chk(irq, 32'h0);
      double_speed_mode_i <= 1'b1;
      acc(`CFG_OFFSET, 1'b0, 8'h08);
      key(`KEY_EN1);
      key(`KEY_SW1);
      idle(150);
      chk(pulses, 32'h2);
      chk(last_len, `RST_PULSE_CYCLES_X2);
      chk(oe_seen, 32'h0);
      rdchk(`CFG_OFFSET, 8'hC8);
      acc(`CFG_OFFSET, 1'b0, 8'h00);
      rdchk(`CFG_OFFSET, 8'h00);
      acc(`IRQ_STAT_OFFSET, 1'b0, 8'h03);
      double_speed_mode_i <= 1'b0;
      timer_prescale_value_i <= 7'h00;
      key(`KEY_EN1);
      key(`KEY_EN2);
      power_down_i <= 1'b1;
      idle(20000);
      chk(pulses, 32'h2);
      power_down_i <= 1'b0;
      idle(12000);
      key(`KEY_EN1);
      key(`KEY_EN2);
      t0 = cyc;
      chk(pulses, 32'h2);
      while (plen == 0 && wn < 20000) begin
         idle(1);
         wn++;
      end
      chk((rise_cyc - t0) inside {[16370:16400]}, 32'h1);
      idle(150);
      chk(last_len, `RST_PULSE_CYCLES);
      chk(oe_seen, 32'h1);
      rdchk(`CFG_OFFSET, 8'h80);
      rdchk(`IRQ_STAT_OFFSET, 8'h01);
      chk(irq, 32'h1);
      complete_run;
   end
endmodule
`default_nettype wire

//--- wdog_defs.svh
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH
`define KEY_OFFSET 8'hA6
`define CFG_OFFSET 8'hA7
`define IRQ_STAT_OFFSET 8'hB0
`define IRQ_MASK_OFFSET 8'hB1
`define CTRL_OFFSET 8'hB2
`define KEY_EN1 8'h1E
`define KEY_EN2 8'hE1
`define KEY_SW1 8'h5A
`define KEY_SW2 8'hA5
`define BIT_OVF 7
`define BIT_SWR 6
`define BIT_RUN 5
`define BIT_IDLE 4
`define BIT_DISRO 3
`define CFG_RESET 8'h00
`define PRESCALE_RESET 7'h05
`define RST_PULSE_CYCLES 7'd96
`define RST_PULSE_CYCLES_X2 7'd48
`define CNT_BITS 14
`define PERIOD_EXTRA_BITS 7
`endif

//--- wdog_pkg.sv
package wdog_pkg;
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_EN_WAIT = 3'b010,
      KEY_SW_WAIT = 3'b100
   } key_state_type;
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avmm_req_type;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avmm_rsp_type;
endpackage
